// ### design/dsl_pkg.sv
package dsl_pkg;
  localparam int ECHO_W = 64;
  localparam int PID_W = 16;
  localparam int PVAL_W = 32;
  localparam int ADDR_W = 8;
  localparam logic FACTORY_HOME_DEF = 1'b0;
  localparam logic [31:0] PRESET_ZERO = 32'h0000_0000;
endpackage : dsl_pkg

// ### design/dsl_edge.sv
`timescale 1ns/10ps
module dsl_edge #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Asynchronous inputs
  input wire logic [W-1:0] async_i,
  // Synchronised level and rising edge
  output logic [W-1:0] level_o,
  output logic [W-1:0] rise_o
);
  logic [W-1:0] meta;
  logic [W-1:0] sync;
  logic [W-1:0] prev;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      sync <= '0;
      prev <= '0;
    end else begin
      meta <= async_i;
      sync <= meta;
      prev <= sync;
    end
  end

  assign level_o = sync;
  assign rise_o = sync & ~prev;
endmodule : dsl_edge

// ### design/dsl_top.sv
`timescale 1ns/10ps
module dsl_top
  import dsl_pkg::*;
#(
  parameter logic FACTORY_HOME = FACTORY_HOME_DEF
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Motion core status
  input wire logic pulse_req_ready_i,
  input wire logic pulse_out_done_i,
  input wire logic mon_select_alarm_i,
  input wire logic mon_coord_bit_i,
  input wire logic mon_alarm_bit_i,
  input wire logic elec_home_active_i,
  input wire logic coord_set_i,
  input wire logic preset_done_i,
  input wire logic home_return_done_i,
  input wire logic sensor_saved_i,
  input wire logic resolution_change_i,
  input wire logic [31:0] preset_position_i,
  input wire logic motion_busy_i,
  input wire logic low_event_trig_i,
  input wire logic high_event_trig_i,
  input wire logic param_store_ack_i,
  // Controller inputs
  input wire logic latch_clear_input_i,
  input wire logic next_step_input_i,
  input wire logic [ECHO_W-1:0] echo_in_i,
  input wire logic servo_on_i,
  input wire logic start_i,
  input wire logic write_req_i,
  input wire logic [PID_W-1:0] param_id_i,
  input wire logic [PVAL_W-1:0] param_value_i,
  input wire logic [ADDR_W-1:0] addr_switch_i,
  // Status outputs
  output logic position_alarm_monitor_output_o,
  output logic pulse_output_ready_flag_o,
  output logic electrical_home_valid_flag_o,
  output logic coordinates_established_flag_o,
  output logic home_reset_needed_flag_o,
  output logic preset_stored_flag_o,
  output logic factory_home_stored_flag_o,
  output logic low_event_latch_o,
  output logic high_event_latch_o,
  output logic next_step_latch_o,
  output logic [ECHO_W-1:0] echo_out_o,
  output logic ready_o,
  output logic write_done_o,
  output logic param_store_o,
  output logic [PID_W-1:0] param_id_o,
  output logic [PVAL_W-1:0] param_value_o,
  output logic [ADDR_W-1:0] addr_o
);
  // ************************************************************
  // Input synchronisers
  // ************************************************************
  localparam int NS = ECHO_W + 5 + ADDR_W;
  logic [NS-1:0] s_lvl;
  logic [NS-1:0] s_rise;
  logic [ECHO_W-1:0] echo_s;
  logic clr_rise;
  logic next_rise;
  logic son_s;
  logic start_s;
  logic wreq_s;
  logic [ADDR_W-1:0] addr_s;
  logic homed;
  logic addr_taken;
  logic [1:0] sync_fill;
  logic wr_busy;

  dsl_edge #(.W(NS)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({addr_switch_i, write_req_i, start_i, servo_on_i,
              next_step_input_i, latch_clear_input_i, echo_in_i}),
    .level_o(s_lvl),
    .rise_o(s_rise)
  );

  assign echo_s = s_lvl[ECHO_W-1:0];
  assign clr_rise = s_rise[ECHO_W];
  assign next_rise = s_rise[ECHO_W+1];
  assign son_s = s_lvl[ECHO_W+2];
  assign start_s = s_lvl[ECHO_W+3];
  assign wreq_s = s_lvl[ECHO_W+4];
  assign addr_s = s_lvl[NS-1:ECHO_W+5];

  // ************************************************************
  // Position monitor and coordinate status
  // ************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      position_alarm_monitor_output_o <= 1'b0;
      electrical_home_valid_flag_o <= 1'b0;
      coordinates_established_flag_o <= 1'b0;
      factory_home_stored_flag_o <= 1'b0;
    end else begin
      position_alarm_monitor_output_o <= mon_select_alarm_i ?
        mon_alarm_bit_i : mon_coord_bit_i;
      electrical_home_valid_flag_o <= elec_home_active_i;
      coordinates_established_flag_o <= coord_set_i;
      factory_home_stored_flag_o <= FACTORY_HOME;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pulse_output_ready_flag_o <= 1'b0;
    end else if (pulse_req_ready_i) begin
      pulse_output_ready_flag_o <= 1'b1;
    end else if (pulse_out_done_i) begin
      pulse_output_ready_flag_o <= 1'b0;
    end
  end

  // Home tracking and rehoming request
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      homed <= 1'b0;
      home_reset_needed_flag_o <= 1'b0;
      preset_stored_flag_o <= 1'b0;
    end else begin
      if (preset_done_i || home_return_done_i) begin
        homed <= 1'b1;
        home_reset_needed_flag_o <= 1'b0;
      end else if (resolution_change_i && homed &&
                   preset_position_i != PRESET_ZERO) begin
        home_reset_needed_flag_o <= 1'b1;
      end
      if (preset_done_i && sensor_saved_i) begin
        preset_stored_flag_o <= 1'b1;
      end else if (resolution_change_i &&
                   preset_position_i != PRESET_ZERO) begin
        preset_stored_flag_o <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Latches
  // ************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      low_event_latch_o <= 1'b0;
      high_event_latch_o <= 1'b0;
      next_step_latch_o <= 1'b0;
    end else begin
      if (low_event_trig_i) begin
        low_event_latch_o <= 1'b1;
      end else if (clr_rise) begin
        low_event_latch_o <= 1'b0;
      end
      if (high_event_trig_i) begin
        high_event_latch_o <= 1'b1;
      end else if (clr_rise) begin
        high_event_latch_o <= 1'b0;
      end
      if (next_rise) begin
        next_step_latch_o <= 1'b1;
      end else if (clr_rise) begin
        next_step_latch_o <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Response echo and address capture
  // ************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      echo_out_o <= '0;
    end else begin
      echo_out_o <= echo_s;
    end
  end

  // Switch synchroniser holds pin values only after two edges
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sync_fill <= '0;
    end else begin
      sync_fill <= {sync_fill[0], 1'b1};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      addr_taken <= 1'b0;
      addr_o <= '0;
    end else if (sync_fill[1] && !addr_taken) begin
      addr_taken <= 1'b1;
      addr_o <= addr_s;
    end
  end

  // ************************************************************
  // Parameter write handshake
  // ************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wr_busy <= 1'b0;
      write_done_o <= 1'b0;
      param_store_o <= 1'b0;
      param_id_o <= '0;
      param_value_o <= '0;
    end else begin
      param_store_o <= 1'b0;
      if (wreq_s && !wr_busy && !write_done_o) begin
        wr_busy <= 1'b1;
        param_store_o <= 1'b1;
        param_id_o <= param_id_i;
        param_value_o <= param_value_i;
      end else if (wr_busy && param_store_ack_i) begin
        wr_busy <= 1'b0;
        write_done_o <= 1'b1;
      end else if (write_done_o && !wreq_s) begin
        write_done_o <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Servo ready
  // ************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= son_s && !motion_busy_i && !start_s;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_latch_hold_set: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) low_event_latch_o && !clr_rise
    |=> low_event_latch_o) else $error("low latch lost");
  a_latch_clear_edge: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) clr_rise && !high_event_trig_i
    |=> !high_event_latch_o) else $error("high latch not cleared");
  a_next_set: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) next_rise |=> next_step_latch_o)
    else $error("next latch not set");
  a_wr_done_drop: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) write_done_o && !wreq_s && !wr_busy
    |=> !write_done_o) else $error("write done stuck");
  a_wr_store_first: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) $rose(write_done_o) |-> $past(wr_busy))
    else $error("done without store");
  a_zero_preset: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) resolution_change_i && !home_reset_needed_flag_o
    && preset_position_i == PRESET_ZERO |=> !home_reset_needed_flag_o)
    else $error("rehome flag with zero preset");
  a_echo_follow: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) 1'b1 |=> echo_out_o == $past(echo_s))
    else $error("echo mismatch");
  a_addr_frozen: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) addr_taken |=> $stable(addr_o))
    else $error("address changed");
  a_ready_drop: assert property (@(posedge ref_clk_i)
    disable iff (!rst_n_i) motion_busy_i |=> !ready_o)
    else $error("ready during motion");
endmodule : dsl_top

// ### verification/dsl_host_model.sv
`timescale 1ns/10ps
module dsl_host_model (
  // Clock, reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Bench commands
  input wire logic wr_go_i,
  input wire logic [15:0] wr_id_i,
  input wire logic [31:0] wr_val_i,
  input wire logic servo_go_i,
  // Device status
  input wire logic write_done_i,
  input wire logic ready_i,
  // Scanner lines
  output logic write_req_o,
  output logic [15:0] id_o,
  output logic [31:0] val_o,
  output logic servo_on_o,
  output logic start_o,
  output logic busy_o
);
  logic [1:0] wst;
  logic [1:0] sst;

  // ****************************************
  // Scanner sequences
  // ****************************************
  assign busy_o = (wst != 2'h0) || (sst == 2'h1) || (sst == 2'h2);

  // Data lines toggle after release and while idle, until the next write go loads them
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wst <= 2'h0;
      write_req_o <= 1'b0;
      id_o <= 16'h0;
      val_o <= 32'h0;
    end else if (wst == 2'h0 && wr_go_i) begin
      id_o <= wr_id_i;
      val_o <= wr_val_i;
      write_req_o <= 1'b1;
      wst <= 2'h1;
    end else if (wst == 2'h1) begin
      if (write_done_i) begin
        write_req_o <= 1'b0;
        wst <= 2'h2;
      end
    end else begin
      id_o <= ~id_o;
      val_o <= ~val_o;
      if (!write_done_i) begin
        wst <= 2'h0;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sst <= 2'h0;
      servo_on_o <= 1'b0;
      start_o <= 1'b0;
    end else if (sst == 2'h0 && servo_go_i) begin
      servo_on_o <= 1'b1;
      sst <= 2'h1;
    end else if (sst == 2'h1 && ready_i) begin
      start_o <= 1'b1;
      sst <= 2'h2;
    end else if (sst == 2'h2 && !ready_i) begin
      start_o <= 1'b0;
      sst <= 2'h3;
    end
  end
endmodule : dsl_host_model

// ### verification/test_dsl_top.sv
`timescale 1ns/10ps
module test_dsl_top;
  import dsl_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] ev;
  logic msel, mcb, mab, eha, cset, mbusy, ack, lclr, nxt, gow, gos;
  logic wreq, son, sta, pbusy, mon, por, ehv, ces, hrn, pst, fhs;
  logic lel, hel, nsl, rdy, wdn, pstr;
  logic [31:0] ppos, pval, gval, pvo;
  logic [15:0] pid, gid, pido;
  logic [7:0] adr, ado, adr_exp;
  logic [63:0] ein, eout;
  logic [47:0] wq[$];
  integer err_count = 0, cmp_count = 0, cyc = 0, seed = 32'h0c60, i, w;

  always #2.5 ref_clk = ~ref_clk;

  dsl_top dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n),
    .pulse_req_ready_i(ev[0]), .pulse_out_done_i(ev[1]),
    .mon_select_alarm_i(msel), .mon_coord_bit_i(mcb),
    .mon_alarm_bit_i(mab), .elec_home_active_i(eha), .coord_set_i(cset),
    .preset_done_i(ev[2]), .home_return_done_i(ev[3]),
    .sensor_saved_i(ev[4]), .resolution_change_i(ev[5]),
    .preset_position_i(ppos), .motion_busy_i(mbusy),
    .low_event_trig_i(ev[6]), .high_event_trig_i(ev[7]),
    .param_store_ack_i(ack), .latch_clear_input_i(lclr),
    .next_step_input_i(nxt), .echo_in_i(ein), .servo_on_i(son),
    .start_i(sta), .write_req_i(wreq), .param_id_i(pid),
    .param_value_i(pval), .addr_switch_i(adr),
    .position_alarm_monitor_output_o(mon), .pulse_output_ready_flag_o(por),
    .electrical_home_valid_flag_o(ehv), .coordinates_established_flag_o(ces),
    .home_reset_needed_flag_o(hrn), .preset_stored_flag_o(pst),
    .factory_home_stored_flag_o(fhs), .low_event_latch_o(lel),
    .high_event_latch_o(hel), .next_step_latch_o(nsl), .echo_out_o(eout),
    .ready_o(rdy), .write_done_o(wdn), .param_store_o(pstr),
    .param_id_o(pido), .param_value_o(pvo), .addr_o(ado));

  dsl_host_model host (.ref_clk_i(ref_clk), .rst_n_i(rst_n),
    .wr_go_i(gow), .wr_id_i(gid), .wr_val_i(gval), .servo_go_i(gos),
    .write_done_i(wdn), .ready_i(rdy), .write_req_o(wreq), .id_o(pid),
    .val_o(pval), .servo_on_o(son), .start_o(sta), .busy_o(pbusy));

  task check(input string n, input logic [63:0] s, input logic [63:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask : check

  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  task tk(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask : tk

  task pls(input integer k);
    ev[k] <= 1'b1;
    tk(1);
    ev <= 8'h00;
    tk(4);
  endtask : pls

  task wait_idle;
    integer j;
    tk(2);
    for (j = 0; j < 60 && pbusy !== 1'b0; j++) tk(1);
    check("host", pbusy, 1'b0);
  endtask : wait_idle

  // Storage acks each store; motion starts on start
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    ack <= pstr;
    if (!rst_n) mbusy <= 1'b0;
    else if (sta) mbusy <= 1'b1;
    if (cyc == 4000) begin
      err_count++;
      final_report();
    end
  end

  always @(negedge ref_clk) begin
    if (pstr === 1'b1) check("store", {pido, pvo}, wq.pop_front());
  end

  initial begin
    {ev, msel, mcb, mab, eha, cset, lclr, nxt, gow, gos} = '0;
    {ppos, ein, gid, gval} = '0;
    adr = 8'($random(seed));
    adr_exp = adr;
    tk(12);
    rst_n <= 1'b1;
    tk(3);
    check("factory", fhs, FACTORY_HOME_DEF);
    adr <= ~adr;
    tk(8);
    check("addr", ado, adr_exp);
    for (i = 0; i < 8; i++) begin
      w = $random(seed);
      {msel, mcb, mab, eha, cset} <= w[4:0];
      ein <= {$random(seed), $random(seed)};
      tk(6);
      check("monitor", mon, msel ? mab : mcb);
      check("ehome", ehv, eha);
      check("coord", ces, cset);
      check("echo", eout, ein);
    end
    pls(0);
    check("pready", por, 1'b1);
    pls(1);
    check("pready", por, 1'b0);
    pls(6);
    check("latches", {lel, hel}, 2'h2);
    pls(7);
    nxt <= 1'b1;
    tk(20);
    check("latches", {lel, hel, nsl}, 3'h7);
    lclr <= 1'b1;
    tk(6);
    check("latches", {lel, hel, nsl}, 3'h0);
    lclr <= 1'b0;
    nxt <= 1'b0;
    tk(6);
    lclr <= 1'b1;
    tk(2);
    ev[6] <= 1'b1;
    tk(1);
    ev[6] <= 1'b0;
    tk(4);
    check("setwins", lel, 1'b1);
    lclr <= 1'b0;
    ppos <= $random(seed) | 32'h1;
    pls(3);
    pls(5);
    check("rehome", hrn, 1'b1);
    pls(2);
    check("rehome", hrn, 1'b0);
    ev[2] <= 1'b1;
    pls(4);
    check("pstored", pst, 1'b1);
    ppos <= PRESET_ZERO;
    pls(5);
    check("rehome", hrn, 1'b0);
    for (i = 0; i < 2; i++) begin
      gid <= 16'($random(seed));
      gval <= $random(seed);
      gow <= 1'b1;
      tk(1);
      gow <= 1'b0;
      wq.push_back({gid, gval});
      wait_idle();
      check("wrdone", wdn, 1'b0);
    end
    check("stores", wq.size(), 0);
    gos <= 1'b1;
    tk(1);
    gos <= 1'b0;
    wait_idle();
    check("ready", {rdy, sta}, 2'h0);
    final_report();
  end
endmodule : test_dsl_top
